// ===== mcsos_defines.vh
`ifndef MCSOS_DEFINES_VH
`define MCSOS_DEFINES_VH

// register indices; byte address is four times the index
`define MCSOS_IDX_MAIN_CLOCK_MODE 16'hFFA1
`define MCSOS_IDX_MAIN_OSC_CONTROL 16'hFFA2
`define MCSOS_IDX_OSC_STABLE_STATUS 16'hFFA3
`define MCSOS_IDX_OSC_STABLE_SELECT 16'hFFA4

// reset values
`define MCSOS_RST_MAIN_CLOCK_MODE 8'h00
`define MCSOS_RST_MAIN_OSC_CONTROL 8'h80
`define MCSOS_RST_OSC_STABLE_STATUS 5'h00
`define MCSOS_RST_OSC_STABLE_SELECT 3'h5

// field positions
`define MCSOS_BIT_MAIN_SELECT 0
`define MCSOS_BIT_MAIN_SOURCE_STATUS 1
`define MCSOS_BIT_SOURCE_SELECT 2
`define MCSOS_BIT_CRYSTAL_HALT 7
`define MCSOS_SEL_MSB 2
`define MCSOS_STATUS_MSB 4

// wait select codes
`define MCSOS_CODE_W11 3'h1
`define MCSOS_CODE_W13 3'h2
`define MCSOS_CODE_W14 3'h3
`define MCSOS_CODE_W15 3'h4
`define MCSOS_CODE_W16 3'h5

// stage thresholds in crystal cycles
`define MCSOS_CNT_W 17
`define MCSOS_CNT_W11 17'h00800
`define MCSOS_CNT_W13 17'h02000
`define MCSOS_CNT_W14 17'h04000
`define MCSOS_CNT_W15 17'h08000
`define MCSOS_CNT_W16 17'h10000

`endif

// ===== mcsos_monitor.sv
`timescale 1ns/10ps
module mcsos_monitor
(
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // bus
   input wire cyc_i,
   input wire stb_i,
   input wire [17:2] adr_i,
   input wire [31:0] dat_o,
   input wire ack_o,
   // control
   input wire stop_exec_i,
   input wire stop_release_i,
   input wire main_clk_sel_o,
   input wire periph_clk_sel_o,
   input wire crystal_enable_o,
   input wire cpu_hold_o,
   input wire in_stop_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_hold_start;
      stop_release_i && in_stop_o && main_clk_sel_o ##2 cpu_hold_o;
   endsequence
   a_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack late");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack too long");
   a_reset_clear: assert property (disable iff (1'b0)
      rst_i |=> !main_clk_sel_o && !periph_clk_sel_o && !cpu_hold_o)
      else $error("reset left a clock select");
   a_main_needs_src: assert property (
      main_clk_sel_o |-> periph_clk_sel_o)
      else $error("main on crystal without source");
   a_src_locked: assert property (
      periph_clk_sel_o |=> periph_clk_sel_o)
      else $error("source select changed twice");
   a_status_upper: assert property (
      ack_o && adr_i == 16'hFFA3 |-> dat_o[31:5] == 27'h0)
      else $error("status upper bits set");
   a_stop_enter: assert property (
      stop_exec_i |-> ##2 in_stop_o && !crystal_enable_o)
      else $error("crystal left running in stop");
   a_hold_min: assert property (s_hold_start |=> cpu_hold_o[*8])
      else $error("cpu hold too short");
   a_hold_cause: assert property (
      $rose(cpu_hold_o) |-> $past(main_clk_sel_o, 2) &&
         $past(stop_release_i, 2))
      else $error("cpu hold without cause");
endmodule // mcsos_monitor

bind mcsos_top mcsos_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .adr_i(adr_i), .dat_o(dat_o),
   .ack_o(ack_o), .stop_exec_i(stop_exec_i),
   .stop_release_i(stop_release_i), .main_clk_sel_o(main_clk_sel_o),
   .periph_clk_sel_o(periph_clk_sel_o), .in_stop_o(in_stop_o),
   .crystal_enable_o(crystal_enable_o), .cpu_hold_o(cpu_hold_o));

// ===== mcsos_pin_sync.v
`timescale 1ns/10ps
// three-stage pin synchroniser; level accepted once stages two and three agree
module mcsos_pin_sync
(
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // pin and result
   input wire pin_i,
   output reg level_o,
   output reg rise_o
);
   reg s1_r;
   reg s2_r;
   reg s3_r;

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_o <= 1'b0;
         rise_o <= 1'b0;
      end
      else
      begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         rise_o <= 1'b0;
         if (s2_r == s3_r)
         begin
            level_o <= s3_r;
            rise_o <= s3_r & ~level_o;
         end
      end
   end
endmodule // mcsos_pin_sync

// ===== mcsos_top.v
`timescale 1ns/10ps
`include "mcsos_defines.vh"
module mcsos_top
(
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [17:2] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // crystal or external clock pin
   input wire crystal_clock_i,
   // standby control from the cpu
   input wire stop_exec_i,
   input wire stop_release_i,
   // clock control outputs
   output reg main_clk_sel_o,
   output reg periph_clk_sel_o,
   output reg crystal_enable_o,
   output reg cpu_hold_o,
   output reg in_stop_o
);
   // stage threshold for a wait code; prohibited codes act as the longest
   function [`MCSOS_CNT_W-1:0] wait_cycles;
      input [`MCSOS_SEL_MSB:0] code;
      begin
         case (code)
            `MCSOS_CODE_W11: wait_cycles = `MCSOS_CNT_W11;
            `MCSOS_CODE_W13: wait_cycles = `MCSOS_CNT_W13;
            `MCSOS_CODE_W14: wait_cycles = `MCSOS_CNT_W14;
            `MCSOS_CODE_W15: wait_cycles = `MCSOS_CNT_W15;
            default: wait_cycles = `MCSOS_CNT_W16;
         endcase
      end
   endfunction

   reg main_select_r;
   reg source_select_r;
   reg source_locked_r;
   reg main_source_status_r;
   reg crystal_halt_r;
   reg [`MCSOS_SEL_MSB:0] wait_select_r;
   reg [`MCSOS_STATUS_MSB:0] stable_status_r;
   reg [`MCSOS_CNT_W-1:0] count_r;
   reg [`MCSOS_CNT_W-1:0] count_nxt;
   reg [`MCSOS_STATUS_MSB:0] status_nxt;
   reg in_stop_r;
   reg hold_r;
   reg [7:0] rd_nxt;

   // reset words kept whole so single bits can be picked by position
   localparam [7:0] MODE_RST = `MCSOS_RST_MAIN_CLOCK_MODE;
   localparam [7:0] OSC_RST = `MCSOS_RST_MAIN_OSC_CONTROL;

   wire xtal_level;
   wire xtal_rise;
   wire req;
   wire wr;
   wire byte_wr;
   wire [`MCSOS_CNT_W-1:0] limit;
   wire at_limit;

   // crystal edges counted in the cpu domain; pin much slower than clk_i
   mcsos_pin_sync u_xtal_sync
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(crystal_clock_i),
      .level_o(xtal_level),
      .rise_o(xtal_rise)
   );

   assign req = cyc_i & stb_i & ~ack_o;
   assign wr = req & we_i;
   // 8-bit registers live in the low lane only
   assign byte_wr = wr & sel_i[0];
   assign limit = wait_cycles(wait_select_r);
   assign at_limit = (count_r >= limit);

   // wishbone answer: one wait state, ack for one cycle
   always @*
   begin
      rd_nxt = 8'h00;
      case (adr_i)
         `MCSOS_IDX_MAIN_CLOCK_MODE:
         begin
            rd_nxt[`MCSOS_BIT_MAIN_SELECT] = main_select_r;
            rd_nxt[`MCSOS_BIT_MAIN_SOURCE_STATUS] = main_source_status_r;
            rd_nxt[`MCSOS_BIT_SOURCE_SELECT] = source_select_r;
         end
         `MCSOS_IDX_MAIN_OSC_CONTROL:
            rd_nxt[`MCSOS_BIT_CRYSTAL_HALT] = crystal_halt_r;
         `MCSOS_IDX_OSC_STABLE_STATUS:
            rd_nxt[`MCSOS_STATUS_MSB:0] = stable_status_r;
         `MCSOS_IDX_OSC_STABLE_SELECT:
            rd_nxt[`MCSOS_SEL_MSB:0] = wait_select_r;
         default:
            rd_nxt = 8'h00;
      endcase
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end
      else
      begin
         ack_o <= req;
         dat_o <= {24'h000000, rd_nxt};
      end
   end

   // software-written registers
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         main_select_r <= MODE_RST[`MCSOS_BIT_MAIN_SELECT];
         source_select_r <= MODE_RST[`MCSOS_BIT_SOURCE_SELECT];
         source_locked_r <= 1'b0;
         crystal_halt_r <= OSC_RST[`MCSOS_BIT_CRYSTAL_HALT];
         wait_select_r <= `MCSOS_RST_OSC_STABLE_SELECT;
      end
      else if (byte_wr)
      begin
         case (adr_i)
            `MCSOS_IDX_MAIN_CLOCK_MODE:
            begin
               main_select_r <= dat_i[`MCSOS_BIT_MAIN_SELECT];
               // first change locks the bit until the next reset
               if (!source_locked_r &&
                   dat_i[`MCSOS_BIT_SOURCE_SELECT] != source_select_r)
               begin
                  source_select_r <= dat_i[`MCSOS_BIT_SOURCE_SELECT];
                  source_locked_r <= 1'b1;
               end
            end
            `MCSOS_IDX_MAIN_OSC_CONTROL:
               crystal_halt_r <= dat_i[`MCSOS_BIT_CRYSTAL_HALT];
            // no guard against writes mid-wait; software keeps off
            `MCSOS_IDX_OSC_STABLE_SELECT:
               wait_select_r <= dat_i[`MCSOS_SEL_MSB:0];
            default:
               main_select_r <= main_select_r;
         endcase
      end
   end

   // stabilisation counter and sticky stages
   always @*
   begin
      count_nxt = count_r;
      status_nxt = stable_status_r;
      if (crystal_halt_r || stop_exec_i)
      begin
         count_nxt = {`MCSOS_CNT_W{1'b0}};
         status_nxt = `MCSOS_RST_OSC_STABLE_STATUS;
      end
      else
      begin
         // only synchronised crystal edges advance it; idle pin adds nothing
         if (xtal_rise && !in_stop_r && !at_limit)
            count_nxt = count_r + 1'b1;
         // stage a at bit 4 down to stage e at bit 0; bits stay set
         if (count_nxt >= `MCSOS_CNT_W11 && limit >= `MCSOS_CNT_W11)
            status_nxt[4] = 1'b1;
         if (count_nxt >= `MCSOS_CNT_W13 && limit >= `MCSOS_CNT_W13)
            status_nxt[3] = 1'b1;
         if (count_nxt >= `MCSOS_CNT_W14 && limit >= `MCSOS_CNT_W14)
            status_nxt[2] = 1'b1;
         if (count_nxt >= `MCSOS_CNT_W15 && limit >= `MCSOS_CNT_W15)
            status_nxt[1] = 1'b1;
         if (count_nxt >= `MCSOS_CNT_W16 && limit >= `MCSOS_CNT_W16)
            status_nxt[0] = 1'b1;
      end
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count_r <= {`MCSOS_CNT_W{1'b0}};
         stable_status_r <= `MCSOS_RST_OSC_STABLE_STATUS;
         in_stop_r <= 1'b0;
         hold_r <= 1'b0;
      end
      else
      begin
         count_r <= count_nxt;
         stable_status_r <= status_nxt;
         if (stop_exec_i)
            in_stop_r <= 1'b1;
         else if (stop_release_i)
            in_stop_r <= 1'b0;
         // cpu on crystal waits out the full selected time
         if (stop_release_i && in_stop_r && main_source_status_r)
            hold_r <= 1'b1;
         else if (hold_r && at_limit)
            hold_r <= 1'b0;
      end
   end

   // clock selects; watchdog and slow or external clocked units are
   // fed outside this block and ignore these selects
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         main_source_status_r <= 1'b0;
         main_clk_sel_o <= 1'b0;
         periph_clk_sel_o <= 1'b0;
         crystal_enable_o <= 1'b0;
         cpu_hold_o <= 1'b0;
         in_stop_o <= 1'b0;
      end
      else
      begin
         main_source_status_r <= source_select_r & main_select_r;
         main_clk_sel_o <= source_select_r & main_select_r;
         periph_clk_sel_o <= source_select_r;
         crystal_enable_o <= ~crystal_halt_r & ~in_stop_r;
         cpu_hold_o <= hold_r;
         in_stop_o <= in_stop_r;
      end
   end
endmodule // mcsos_top

// ===== mcsos_xtal_model.sv
`timescale 1ns/10ps
module mcsos_xtal_model
#(
   parameter real HALF_NS = 15.0
)
(
   // enable from the block
   input wire enable_i,
   // crystal pin
   output logic clk_o
);
   // held low while disabled so no edge is counted before start
   initial
   begin
      clk_o = 1'b0;
      #1.3;
      forever
      begin
         #(HALF_NS);
         clk_o = enable_i ? ~clk_o : 1'b0;
      end
   end
endmodule // mcsos_xtal_model

// ===== tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
   failures++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic stop_exec_i = 0, stop_release_i = 0, crystal_clock_i;
   logic [17:2] adr_i = 0;
   logic [3:0] sel_i = 0;
   logic [31:0] dat_i = 0, dat_o, q;
   logic ack_o, main_clk_sel_o, periph_clk_sel_o, crystal_enable_o;
   logic cpu_hold_o, in_stop_o;
   int failures = 0, checks_done = 0, n;
   mcsos_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .crystal_clock_i(crystal_clock_i), .stop_exec_i(stop_exec_i),
      .stop_release_i(stop_release_i), .main_clk_sel_o(main_clk_sel_o),
      .periph_clk_sel_o(periph_clk_sel_o), .in_stop_o(in_stop_o),
      .crystal_enable_o(crystal_enable_o), .cpu_hold_o(cpu_hold_o));
   mcsos_xtal_model xtal (.enable_i(crystal_enable_o),
      .clk_o(crystal_clock_i));
   initial
      forever #2.5 clk_i = ~clk_i;
   task stop_test;
      if (failures == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // one classic cycle; the gap edge keeps two requests apart
   task wb(input logic w, input logic [15:0] a, input logic [7:0] d,
           input logic [3:0] s);
      int k;
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      sel_i <= s;
      k = 0;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && k < 20)
      begin
         k++;
         @(posedge clk_i);
      end
      q = dat_o;
      cyc_i <= 0;
      stb_i <= 0;
      @(posedge clk_i);
   endtask
   task rd(input logic [15:0] a, input logic [7:0] e, input string nm);
      wb(0, a, 8'h00, 4'hF);
      `CHK(nm, {24'h0, e}, q)
   endtask
   // registered outputs settle one edge after the pulse ends
   task pulse(input bit rel);
      if (rel)
         stop_release_i <= 1;
      else
         stop_exec_i <= 1;
      @(posedge clk_i);
      stop_release_i <= 0;
      stop_exec_i <= 0;
      repeat (2) @(posedge clk_i);
   endtask
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      rd(16'hFFA1, 8'h00, "mode");
      rd(16'hFFA3, 8'h00, "status");
      rd(16'hFFA4, 8'h05, "select");
      wb(1, 16'hFFA4, 8'h01, 4'h0);
      rd(16'hFFA4, 8'h05, "select lane");
      wb(1, 16'hFFA4, 8'h01, 4'h1);
      rd(16'hFFA4, 8'h01, "select code");
      wb(1, 16'hFFA1, 8'h04, 4'h1);
      `CHK("periph", 2'b01, {main_clk_sel_o, periph_clk_sel_o})
      rd(16'hFFA1, 8'h04, "mode src");
      wb(1, 16'hFFA1, 8'h01, 4'h1);
      rd(16'hFFA1, 8'h07, "mode lock");
      `CHK("both", 2'b11, {main_clk_sel_o, periph_clk_sel_o})
      wb(1, 16'hFFA3, 8'h1F, 4'h1);
      rd(16'hFFA3, 8'h00, "status ro");
      rd(16'h0010, 8'h00, "unmapped");
      wb(1, 16'hFFA2, 8'h00, 4'h1);
      q = 0;
      n = 0;
      while (q[4] !== 1'b1 && n < 6000)
      begin
         n++;
         wb(0, 16'hFFA3, 8'h00, 4'hF);
      end
      `CHK("stage time", 1'b1, n > 4000 && n < 4200)
      rd(16'hFFA3, 8'h10, "stage a");
      pulse(0);
      `CHK("xtal stop", 1'b0, crystal_enable_o)
      rd(16'hFFA3, 8'h00, "status stop");
      pulse(1);
      n = 0;
      while (cpu_hold_o === 1'b1 && n < 20000)
      begin
         n++;
         @(posedge clk_i);
      end
      `CHK("hold time", 1'b1, n > 12000 && n < 12600)
      rd(16'hFFA3, 8'h10, "status wake");
      wb(1, 16'hFFA2, 8'h80, 4'h1);
      rd(16'hFFA3, 8'h00, "status halt");
      `CHK("xtal halt", 1'b0, crystal_enable_o)
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      rd(16'hFFA1, 8'h00, "mode again");
      wb(1, 16'hFFA1, 8'h04, 4'h1);
      rd(16'hFFA1, 8'h04, "lock freed");
      stop_test;
   end
   initial
   begin
      #400000;
      failures++;
      stop_test;
   end
endmodule // tb_top
